/* lpes_pkg.sv */
// constants shared by the pin edge select block
package lpes_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_SER_RX  = 8'h08;
  localparam logic [7:0] ADDR_SER_TX  = 8'h0C;
  localparam logic [7:0] ADDR_TX_DATA = 8'h10;
  localparam logic [7:0] ADDR_RX_PAT  = 8'h14;

  // control field positions and reset values
  localparam int          CTRL_TX_EDGE = 0;
  localparam int          CTRL_RX_EDGE = 1;
  localparam int          CTRL_SRC_LO  = 2;
  localparam int          CTRL_W       = 4;
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [15:0] PAT_RST      = 16'h0000;

  // status field positions
  localparam int ST_BYTE_RDY = 0;
  localparam int ST_HW_MODE  = 1;
  localparam int ST_TEST     = 2;
  localparam int ST_SHARED   = 3;
  localparam int ST_TX_LVL   = 4;
  localparam int ST_INPUT_EDGE_SELECT     = 5;
  localparam int ST_OUTPUT_EDGE_SELECT     = 6;
  localparam int ST_CNT_LO   = 8;

  // bit counters
  localparam int         CNT_W    = 3;
  localparam logic [2:0] CNT_LAST = 3'h7;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE  = 3'h1;
  localparam logic [7:0] TXB_ONE  = 8'h01;

  // synchroniser lanes
  localparam int SY_SCLK = 0;
  localparam int SY_SDI  = 1;
  localparam int SY_TX_POSITIVE_DATA = 2;
  localparam int SY_TX_NEGATIVE_DATA = 3;
  localparam int SY_TX_CLOCK = 4;
  localparam int SY_MCLK = 5;
  localparam int SY_RCLK = 6;
  localparam int SY_TEST = 7;
  localparam int SY_HWM  = 8;
  localparam int SY_CES  = 9;
  localparam int SY_INPUT_EDGE_SELECT = 10;
  localparam int SY_OUTPUT_EDGE_SELECT = 11;
  localparam int SY_W    = 12;

  // transmit clock source
  typedef enum logic [1:0] {
    LPES_SRC_PIN    = 2'b00,
    LPES_SRC_MASTER = 2'b01,
    LPES_SRC_RECOV  = 2'b10,
    LPES_SRC_PIN2   = 2'b11
  } lpes_src_t;

endpackage

/* lpes_sync.sv */
// two-stage synchroniser with edge detection for pin inputs
`timescale 1ns/10ps
`default_nettype none
module lpes_sync
#(
  parameter int W = 1
)
(
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clk_en,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // first stage feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else if (i_clk_en)
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;
  assign o_fall  = ~sync_q & prev_q;

endmodule
`default_nettype wire

/* lpes_pin_edge.sv */
// serial port, transmit sampling and receive retiming with edge selects
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module lpes_pin_edge
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_serial_clk,
  input  wire logic        i_serial_ctrl_in,
  input  wire logic        i_input_edge_select,
  input  wire logic        i_output_edge_select,
  output logic             o_serial_ctrl_out,
  output logic             o_serial_ctrl_out_oe,
  input  wire logic        i_tx_clock,
  input  wire logic        i_tx_positive_data,
  input  wire logic        i_tx_negative_data,
  input  wire logic        i_master_clock,
  input  wire logic        i_recovered_clock,
  input  wire logic        i_test_tristate,
  input  wire logic        i_pin_config_mode,
  input  wire logic        i_shared_edge_select_pin,
  output logic             o_rx_positive_data,
  output logic             o_rx_positive_data_oe,
  output logic             o_rx_negative_data,
  output logic             o_rx_negative_data_oe
);

  logic [lpes_pkg::SY_W-1:0] pin_in;
  logic [lpes_pkg::SY_W-1:0] lvl;
  logic [lpes_pkg::SY_W-1:0] rise;
  logic [lpes_pkg::SY_W-1:0] fall;

  assign pin_in = {i_output_edge_select, i_input_edge_select,
                   i_shared_edge_select_pin, i_pin_config_mode,
                   i_test_tristate, i_recovered_clock, i_master_clock,
                   i_tx_clock, i_tx_negative_data, i_tx_positive_data,
                   i_serial_ctrl_in, i_serial_clk};

  lpes_sync #(.W(lpes_pkg::SY_W)) u_sync
  (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_async   (pin_in),
    .o_level   (lvl),
    .o_rise    (rise),
    .o_fall    (fall)
  );

  // register file state
  logic [lpes_pkg::CTRL_W-1:0] ctrl_q;
  logic [7:0]                  ser_tx_q;
  logic [15:0]                 rx_pat_q;
  logic                        byte_rdy_q;
  logic                        wr_pend_q;
  logic [7:0]                  wr_addr_q;
  logic [31:0]                 hrdata_q;

  // serial port state
  logic [7:0]               in_sh_q;
  logic [lpes_pkg::CNT_W-1:0] in_cnt_q;
  logic [7:0]               ser_rx_q;
  logic [7:0]               out_sh_q;
  logic [lpes_pkg::CNT_W-1:0] out_cnt_q;
  logic                     sdo_q;

  // transmit and receive state
  logic [7:0]               tx_pos_sh_q;
  logic [7:0]               tx_neg_sh_q;
  logic [7:0]               tx_bits_q;
  logic [lpes_pkg::CNT_W-1:0] rx_idx_q;
  logic                     rx_pos_q;
  logic                     rx_neg_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // bus decode
  logic       addr_take;
  logic       wr_now;
  logic [7:0] a_lo;
  assign a_lo      = i_haddr[7:0];
  assign addr_take = i_clk_en & i_hsel & i_hready & i_htrans[1];
  assign wr_now    = i_clk_en & wr_pend_q;

  // edge selection
  logic      hw_mode;
  logic      tx_edge_eff;
  logic      rx_edge_eff;
  lpes_pkg::lpes_src_t src;
  logic      tx_clk_lvl;
  logic      tx_clk_rise;
  logic      tx_clk_fall;
  logic      tx_evt;
  logic      rx_evt;
  logic      cap_evt;
  logic      launch_evt;
  logic      byte_done;
  logic      test_on;

  assign hw_mode = lvl[lpes_pkg::SY_HWM];
  assign test_on = lvl[lpes_pkg::SY_TEST];
  // pin mode: one shared pin sets both edges
  assign tx_edge_eff = hw_mode ? lvl[lpes_pkg::SY_CES]
                               : ctrl_q[lpes_pkg::CTRL_TX_EDGE];
  assign rx_edge_eff = hw_mode ? lvl[lpes_pkg::SY_CES]
                               : ctrl_q[lpes_pkg::CTRL_RX_EDGE];
  assign src = lpes_pkg::lpes_src_t'(ctrl_q[lpes_pkg::CTRL_SRC_LO +: 2]);

  // muxing edge pulses, not levels, so a source switch makes no false edge
  always_comb
  begin
    case (src)
      lpes_pkg::LPES_SRC_MASTER:
      begin
        tx_clk_lvl  = lvl[lpes_pkg::SY_MCLK];
        tx_clk_rise = rise[lpes_pkg::SY_MCLK];
        tx_clk_fall = fall[lpes_pkg::SY_MCLK];
      end
      lpes_pkg::LPES_SRC_RECOV:
      begin
        tx_clk_lvl  = lvl[lpes_pkg::SY_RCLK];
        tx_clk_rise = rise[lpes_pkg::SY_RCLK];
        tx_clk_fall = fall[lpes_pkg::SY_RCLK];
      end
      default:
      begin
        tx_clk_lvl  = lvl[lpes_pkg::SY_TX_CLOCK];
        tx_clk_rise = rise[lpes_pkg::SY_TX_CLOCK];
        tx_clk_fall = fall[lpes_pkg::SY_TX_CLOCK];
      end
    endcase
  end

  assign tx_evt = i_clk_en & (tx_edge_eff ? tx_clk_rise : tx_clk_fall);
  assign rx_evt = i_clk_en & (rx_edge_eff ? fall[lpes_pkg::SY_RCLK]
                                          : rise[lpes_pkg::SY_RCLK]);
  assign cap_evt = i_clk_en & (lvl[lpes_pkg::SY_INPUT_EDGE_SELECT] ? fall[lpes_pkg::SY_SCLK]
                                                      : rise[lpes_pkg::SY_SCLK]);
  // output changes on the edge opposite the one where it is valid
  assign launch_evt = i_clk_en & (lvl[lpes_pkg::SY_OUTPUT_EDGE_SELECT] ? fall[lpes_pkg::SY_SCLK]
                                                         : rise[lpes_pkg::SY_SCLK]);
  assign byte_done = cap_evt & (in_cnt_q == lpes_pkg::CNT_LAST);

  // bus address phase capture and read data
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end
    else if (i_clk_en)
    begin
      wr_pend_q <= addr_take & i_hwrite;
      if (addr_take)
      begin
        wr_addr_q <= a_lo;
      end
      if (addr_take & ~i_hwrite)
      begin
        hrdata_q <= 32'h0000_0000;
        if (hit(a_lo, lpes_pkg::ADDR_CTRL))
          hrdata_q[lpes_pkg::CTRL_W-1:0] <= ctrl_q;
        if (hit(a_lo, lpes_pkg::ADDR_STATUS))
        begin
          hrdata_q[lpes_pkg::ST_BYTE_RDY] <= byte_rdy_q;
          hrdata_q[lpes_pkg::ST_HW_MODE]  <= hw_mode;
          hrdata_q[lpes_pkg::ST_TEST]     <= test_on;
          hrdata_q[lpes_pkg::ST_SHARED]   <= lvl[lpes_pkg::SY_CES];
          hrdata_q[lpes_pkg::ST_TX_LVL]   <= tx_clk_lvl;
          hrdata_q[lpes_pkg::ST_INPUT_EDGE_SELECT]     <= lvl[lpes_pkg::SY_INPUT_EDGE_SELECT];
          hrdata_q[lpes_pkg::ST_OUTPUT_EDGE_SELECT]     <= lvl[lpes_pkg::SY_OUTPUT_EDGE_SELECT];
          hrdata_q[lpes_pkg::ST_CNT_LO +: 8] <= tx_bits_q;
        end
        if (hit(a_lo, lpes_pkg::ADDR_SER_RX))
          hrdata_q[7:0] <= ser_rx_q;
        if (hit(a_lo, lpes_pkg::ADDR_SER_TX))
          hrdata_q[7:0] <= ser_tx_q;
        if (hit(a_lo, lpes_pkg::ADDR_TX_DATA))
          hrdata_q[15:0] <= {tx_neg_sh_q, tx_pos_sh_q};
        if (hit(a_lo, lpes_pkg::ADDR_RX_PAT))
          hrdata_q[15:0] <= rx_pat_q;
      end
    end
  end

  // bus data phase writes
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_q   <= lpes_pkg::CTRL_RST;
      ser_tx_q <= lpes_pkg::BYTE_RST;
      rx_pat_q <= lpes_pkg::PAT_RST;
    end
    else if (wr_now)
    begin
      if (hit(wr_addr_q, lpes_pkg::ADDR_CTRL))
        ctrl_q <= i_hwdata[lpes_pkg::CTRL_W-1:0];
      if (hit(wr_addr_q, lpes_pkg::ADDR_SER_TX))
        ser_tx_q <= i_hwdata[7:0];
      if (hit(wr_addr_q, lpes_pkg::ADDR_RX_PAT))
        rx_pat_q <= i_hwdata[15:0];
    end
  end

  // byte ready: a new byte beats a same-cycle clear
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      byte_rdy_q <= 1'b0;
    else if (i_clk_en)
      byte_rdy_q <= byte_done | (byte_rdy_q &
                    ~(wr_pend_q & hit(wr_addr_q, lpes_pkg::ADDR_STATUS)
                      & i_hwdata[lpes_pkg::ST_BYTE_RDY]));
  end

  // serial input shift
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      in_sh_q  <= 8'h00;
      in_cnt_q <= lpes_pkg::CNT_ZERO;
      ser_rx_q <= lpes_pkg::BYTE_RST;
    end
    else if (cap_evt)
    begin
      in_sh_q  <= {in_sh_q[6:0], lvl[lpes_pkg::SY_SDI]};
      in_cnt_q <= in_cnt_q + lpes_pkg::CNT_ONE;
      if (byte_done)
        ser_rx_q <= {in_sh_q[6:0], lvl[lpes_pkg::SY_SDI]};
    end
  end

  // serial output shift, msb first
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_sh_q  <= 8'h00;
      out_cnt_q <= lpes_pkg::CNT_ZERO;
      sdo_q     <= 1'b0;
    end
    else if (launch_evt)
    begin
      out_cnt_q <= out_cnt_q + lpes_pkg::CNT_ONE;
      if (out_cnt_q == lpes_pkg::CNT_ZERO)
      begin
        sdo_q    <= ser_tx_q[7];
        out_sh_q <= {ser_tx_q[6:0], 1'b0};
      end
      else
      begin
        sdo_q    <= out_sh_q[7];
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

  // transmit formatter input stage
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_pos_sh_q <= 8'h00;
      tx_neg_sh_q <= 8'h00;
      tx_bits_q   <= 8'h00;
    end
    else if (tx_evt)
    begin
      tx_pos_sh_q <= {tx_pos_sh_q[6:0], lvl[lpes_pkg::SY_TX_POSITIVE_DATA]};
      tx_neg_sh_q <= {tx_neg_sh_q[6:0], lvl[lpes_pkg::SY_TX_NEGATIVE_DATA]};
      tx_bits_q   <= tx_bits_q + lpes_pkg::TXB_ONE;
    end
  end

  // receive outputs replay the pattern register
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_idx_q <= lpes_pkg::CNT_ZERO;
      rx_pos_q <= 1'b0;
      rx_neg_q <= 1'b0;
    end
    else if (rx_evt)
    begin
      rx_idx_q <= rx_idx_q + lpes_pkg::CNT_ONE;
      rx_pos_q <= rx_pat_q[{1'b0, rx_idx_q}];
      rx_neg_q <= rx_pat_q[{1'b1, rx_idx_q}];
    end
  end

  // zero wait states; a frozen clock enable stalls the bus
  assign o_hreadyout = i_clk_en;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = hrdata_q;

  assign o_serial_ctrl_out     = sdo_q;
  assign o_rx_positive_data    = rx_pos_q;
  assign o_rx_negative_data    = rx_neg_q;
  assign o_serial_ctrl_out_oe  = ~test_on;
  assign o_rx_positive_data_oe = ~test_on;
  assign o_rx_negative_data_oe = ~test_on;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  serial_cap_a: assert property (cap_evt |=> in_sh_q[0] == $past(lvl[lpes_pkg::SY_SDI]))
    else $error("serial input not captured on selected edge");
  cap_edge_a: assert property (i_clk_en && rise[lpes_pkg::SY_SCLK] && lvl[lpes_pkg::SY_INPUT_EDGE_SELECT] |-> !cap_evt)
    else $error("serial input captured on wrong edge");
  sdo_hold_a: assert property (!launch_evt |=> $stable(sdo_q))
    else $error("serial output changed off its launch edge");
  tx_sample_a: assert property (tx_evt |=> tx_neg_sh_q[0] == $past(lvl[lpes_pkg::SY_TX_NEGATIVE_DATA]))
    else $error("transmit data not sampled on selected edge");
  tx_count_a: assert property (tx_evt |=> tx_bits_q == $past(tx_bits_q) + lpes_pkg::TXB_ONE)
    else $error("formatter did not advance");
  tx_still_a: assert property (!tx_evt |=> $stable(tx_pos_sh_q) && $stable(tx_bits_q))
    else $error("formatter moved without a clock edge");
  src_master_a: assert property (src == lpes_pkg::LPES_SRC_MASTER |-> tx_clk_lvl == lvl[lpes_pkg::SY_MCLK])
    else $error("master clock not selected");
  src_recov_a: assert property (src == lpes_pkg::LPES_SRC_RECOV
    |-> tx_clk_lvl == lvl[lpes_pkg::SY_RCLK])
    else $error("recovered clock not selected");
  tristate_a: assert property (test_on |-> !o_serial_ctrl_out_oe && !o_rx_positive_data_oe && !o_rx_negative_data_oe)
    else $error("outputs driven during test");
  pin_mode_a: assert property (hw_mode && !lvl[lpes_pkg::SY_CES] && i_clk_en && tx_clk_rise |-> !tx_evt)
    else $error("pin mode sampled on wrong transmit edge");
  rx_update_a: assert property (!rx_evt |=> $stable(o_rx_positive_data))
    else $error("receive data moved off its edge");

  byte_cov_c: cover property (byte_done);
  tx_recov_c: cover property (tx_evt && src == lpes_pkg::LPES_SRC_RECOV);
  pin_mode_c: cover property (hw_mode && rx_evt);
  test_c:     cover property (test_on ##1 !test_on);

endmodule
`default_nettype wire

/* lpes_far_model.sv */
// far-side model: serial host controller and transmit framer
`timescale 1ns/10ps
`default_nettype none
module lpes_far_model
(
  input  wire logic i_serial_ctrl_out,
  output logic      o_serial_clk,
  output logic      o_serial_ctrl_in,
  output logic      o_tx_clock,
  output logic      o_master_clock,
  output logic      o_recovered_clock,
  output logic      o_tx_positive_data,
  output logic      o_tx_negative_data
);
  initial
  begin
    o_serial_clk       = 1'b0;
    o_serial_ctrl_in   = 1'b0;
    o_tx_clock         = 1'b0;
    o_master_clock     = 1'b0;
    o_recovered_clock  = 1'b0;
    o_tx_positive_data = 1'b0;
    o_tx_negative_data = 1'b0;
  end

  // non-blocking so a change on a clock edge never races the synchroniser
  task automatic drive_clk(input logic [1:0] src, input logic v);
    case (src)
      2'h1:    o_master_clock <= v;
      2'h2:    o_recovered_clock <= v;
      default: o_tx_clock <= v;
    endcase
  endtask

  // all clock lines moved together so a source switch sees no edge
  task automatic clocks_rest(input logic lvl);
    o_tx_clock        <= lvl;
    o_master_clock    <= lvl;
    o_recovered_clock <= lvl;
    #80;
  endtask

  task automatic serial_rest(input logic lvl);
    o_serial_clk <= lvl;
    #80;
  endtask

  // data moves on the first edge, 40 ns clear of the capturing edge
  task automatic serial_frame(input  logic       idle,
                              input  logic [7:0] tx,
                              output logic [7:0] rx);
    for (int b = 7; b >= 0; b--)
    begin
      o_serial_clk     <= ~idle;
      o_serial_ctrl_in <= tx[b];
      #40;
      o_serial_clk <= idle;
      rx[b] = i_serial_ctrl_out;
      #40;
    end
    // released line must not keep showing the last bit
    o_serial_ctrl_in <= ~tx[0];
  endtask

  // decoy data around the unselected edge, real data around the other
  task automatic tx_bits(input logic [1:0] src,
                         input logic       idle,
                         input logic       pos,
                         input logic       neg);
    for (int b = 0; b < 8; b++)
    begin
      o_tx_positive_data <= ~pos;
      o_tx_negative_data <= ~neg;
      #40;
      drive_clk(src, ~idle);
      #40;
      o_tx_positive_data <= pos;
      o_tx_negative_data <= neg;
      #40;
      drive_clk(src, idle);
      #40;
    end
  endtask
endmodule
`default_nettype wire

/* lpes_pin_edge_test.sv */
// self-checking bench for the pin edge select block
`timescale 1ns/10ps
`default_nettype none
module lpes_pin_edge_test;
  logic        i_sys_clk;
  logic        i_rst_n;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        input_edge_select, output_edge_select, test_pin, pin_mode, shared;
  logic        sclk, serial_ctrl_in, serial_ctrl_out, sdo_oe;
  logic        tx_clock, mclk, rclk, tx_positive_data, tx_negative_data;
  logic        rxp, rxp_oe, rxn, rxn_oe;
  logic [7:0]  got;
  int          failures;
  int          comparisons;
  // transmit cases: control value, pin mode, shared pin, rising sample
  logic [3:0]  tx_ctrl [7] = '{4'h0, 4'h1, 4'h5, 4'h8, 4'hD, 4'h1, 4'h0};
  logic [6:0]  tx_pm   = 7'h60;
  logic [6:0]  tx_sh   = 7'h40;
  logic [6:0]  tx_rise = 7'h56;
  logic [7:0]  regs [5] = '{lpes_pkg::ADDR_CTRL, lpes_pkg::ADDR_SER_RX,
    lpes_pkg::ADDR_SER_TX, lpes_pkg::ADDR_TX_DATA, lpes_pkg::ADDR_RX_PAT};

  always #5 i_sys_clk = ~i_sys_clk;

  lpes_pin_edge i_dut
  (
    .i_sys_clk                (i_sys_clk),
    .i_rst_n                  (i_rst_n),
    .i_clk_en                 (1'b1),
    .i_hsel                   (hsel),
    .i_haddr                  (haddr),
    .i_htrans                 (htrans),
    .i_hwrite                 (hwrite),
    .i_hsize                  (3'h2),
    .i_hwdata                 (hwdata),
    .i_hready                 (hreadyout),
    .o_hrdata                 (hrdata),
    .o_hreadyout              (hreadyout),
    .o_hresp                  (hresp),
    .i_serial_clk             (sclk),
    .i_serial_ctrl_in         (serial_ctrl_in),
    .i_input_edge_select      (input_edge_select),
    .i_output_edge_select     (output_edge_select),
    .o_serial_ctrl_out        (serial_ctrl_out),
    .o_serial_ctrl_out_oe     (sdo_oe),
    .i_tx_clock               (tx_clock),
    .i_tx_positive_data       (tx_positive_data),
    .i_tx_negative_data       (tx_negative_data),
    .i_master_clock           (mclk),
    .i_recovered_clock        (rclk),
    .i_test_tristate          (test_pin),
    .i_pin_config_mode        (pin_mode),
    .i_shared_edge_select_pin (shared),
    .o_rx_positive_data       (rxp),
    .o_rx_positive_data_oe    (rxp_oe),
    .o_rx_negative_data       (rxn),
    .o_rx_negative_data_oe    (rxn_oe)
  );

  lpes_far_model i_far
  (
    .i_serial_ctrl_out  (serial_ctrl_out),
    .o_serial_clk       (sclk),
    .o_serial_ctrl_in   (serial_ctrl_in),
    .o_tx_clock         (tx_clock),
    .o_master_clock     (mclk),
    .o_recovered_clock  (rclk),
    .o_tx_positive_data (tx_positive_data),
    .o_tx_negative_data (tx_negative_data)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // single transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic rclk_step(input logic v);
    i_far.drive_clk(2'h2, v);
    repeat (8) @(posedge i_sys_clk);
  endtask

  // zero pattern flushed first so any bit index gives a known value
  task automatic rx_case(input logic pm, input logic sh,
                         input logic [3:0] c, input logic upd_fall);
    logic lvl;
    lvl = rclk;
    pin_mode <= pm;
    shared   <= sh;
    ahb(1'b1, lpes_pkg::ADDR_CTRL, {28'h0, c});
    ahb(1'b1, lpes_pkg::ADDR_RX_PAT, 32'h0);
    rclk_step(~lvl);
    rclk_step(lvl);
    ahb(1'b1, lpes_pkg::ADDR_RX_PAT, 32'h00FF);
    rclk_step(~lvl);
    check({30'h0, rxn, rxp}, {31'h0, upd_fall == lvl});
    rclk_step(lvl);
    check({30'h0, rxn, rxp}, 32'h1);
  endtask

  task automatic report_and_stop();
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    i_sys_clk   = 1'b0;
    i_rst_n     = 1'b0;
    hsel        = 1'b0;
    hwrite      = 1'b0;
    htrans      = 2'b00;
    haddr       = 32'h0;
    hwdata      = 32'h0;
    input_edge_select        = 1'b0;
    output_edge_select        = 1'b0;
    test_pin    = 1'b0;
    pin_mode    = 1'b0;
    shared      = 1'b0;
    failures    = 0;
    comparisons = 0;
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    foreach (regs[i])
      rd_chk(regs[i], 32'h0);
    ahb(1'b1, 8'h18, 32'hFFFF_FFFF);
    rd_chk(8'h18, 32'h0);
    ahb(1'b1, lpes_pkg::ADDR_TX_DATA, 32'hFFFF_FFFF);
    rd_chk(lpes_pkg::ADDR_TX_DATA, 32'h0);
    check({31'h0, hresp}, 32'h0);
    test_pin <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    check({29'h0, sdo_oe, rxp_oe, rxn_oe}, 32'h0);
    test_pin <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    check({29'h0, sdo_oe, rxp_oe, rxn_oe}, 32'h7);
    input_edge_select <= 1'b1;
    ahb(1'b1, lpes_pkg::ADDR_SER_TX, 32'hA5);
    i_far.serial_frame(1'b0, 8'h3C, got);
    @(posedge i_sys_clk);
    check({24'h0, got}, 32'hA5);
    rd_chk(lpes_pkg::ADDR_SER_RX, 32'h3C);
    ahb(1'b0, lpes_pkg::ADDR_STATUS, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    ahb(1'b1, lpes_pkg::ADDR_STATUS, 32'h1);
    ahb(1'b0, lpes_pkg::ADDR_STATUS, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    // select launch on fall before the clock rises, so no stray launch
    output_edge_select <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    i_far.serial_rest(1'b1);
    @(posedge i_sys_clk);
    input_edge_select <= 1'b0;
    ahb(1'b1, lpes_pkg::ADDR_SER_TX, 32'h5A);
    i_far.serial_frame(1'b1, 8'hC3, got);
    @(posedge i_sys_clk);
    check({24'h0, got}, 32'h5A);
    rd_chk(lpes_pkg::ADDR_SER_RX, 32'hC3);
    // clock level changed under the old edge so it is never sampled
    for (int k = 0; k < 7; k++)
    begin
      i_far.clocks_rest(tx_rise[k]);
      @(posedge i_sys_clk);
      pin_mode <= tx_pm[k];
      shared   <= tx_sh[k];
      ahb(1'b1, lpes_pkg::ADDR_CTRL, {28'h0, tx_ctrl[k]});
      repeat (4) @(posedge i_sys_clk);
      i_far.tx_bits(tx_ctrl[k][3:2], tx_rise[k], ~k[0], k[0]);
      @(posedge i_sys_clk);
      rd_chk(lpes_pkg::ADDR_TX_DATA, k[0] ? 32'hFF00 : 32'h00FF);
      ahb(1'b0, lpes_pkg::ADDR_STATUS, 32'h0);
      check({24'h0, rd[15:8]}, 32'((k + 1) * 8));
    end
    rx_case(1'b1, 1'b1, 4'h0, 1'b1);
    rx_case(1'b0, 1'b0, 4'h0, 1'b0);
    rx_case(1'b0, 1'b0, 4'h2, 1'b1);
    rx_case(1'b1, 1'b0, 4'h2, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
